// *** rtl/suspend_mode_controller.sv ***
/*
 suspend mode controller: key register, power_control register,
 idle / power-down state machine, clock gating and oscillator warm-up.
 assumes sfr writes and instruction-completion strobes arrive in the
 sys_clk domain; interrupt and reset causes arrive as async levels.
*/
// Behaviour
// - idle gates cpu clock, halts cpu; peripheral clocks keep running.
// - cpu state is retained by holding clocks, never by reset.
// - idle entry needs key 0x55 then directly the idle bit set.
// - broken idle sequence clears key or idle bit next cycle.
// - power-down entry needs key 0x55 then directly power-down bit.
// - broken power-down sequence clears key or power-down bit, run on.
// - the mode-bit write is the last instruction before suspension.
// - interrupt in idle restores clock, clears key and idle bit.
// - reset in suspend restores clock, clears key and mode bits.
// - power-down stops cpu and peripheral clocks; watchdog runs.
// - both bits set enters power-down; exit clears both bits.
// - external interrupt wakes power-down after oscillator warm-up.
// - reset exit from power-down holds cpu clock through warm-up.
// - power_control at 87h: baud, serial, flags, power-down, idle; zero.
`timescale 1ns/1ps
module suspend_mode_controller
    import suspend_pkg::*;
#(
    parameter int WARMUP_CYC = WARMUP_CYC_DEF
) (
    // clock and reset
    input  wire logic     sys_clk,
    input  wire logic     rst,
    // sfr access from cpu core
    input  wire sfr_req_t sfr_req,
    input  wire logic [7:0] rd_addr,
    output logic [7:0]    rd_data,
    // wake sources and watchdog enable
    input  wire logic     irq_any,
    input  wire logic     ext_irq_any,
    input  wire logic     wdt_enabled,
    // clock and status outputs
    output logic          cpu_clk_en,
    output logic          periph_clk_en,
    output logic          osc_run,
    output logic          wdt_clk_en,
    output logic          wake_irq,
    output logic [7:0]    power_control
);
    logic       irq_s1_r, irq_s2_r, ext_s1_r, ext_s2_r;
    logic [7:0] pctl_r, pctl_nxt, skey_r, skey_nxt, rd_r, rd_nxt;
    logic       armed_r, armed_nxt, wake_r, wake_nxt;
    logic       cpu_en_r, cpu_en_nxt, per_en_r, per_en_nxt;
    logic       osc_r, osc_nxt, wdt_en_r, wdt_en_nxt;
    logic [WARM_W-1:0] warm_r, warm_nxt;
    logic [WARM_W-1:0] seen_r, seen_nxt;
    logic       pend_r, pend_nxt;
    pm_state_t  st_r, st_nxt;
    logic       wr_pctl, wr_skey;

    assign wr_pctl = sfr_req.wr && sfr_req.addr == PCTL_ADDR;
    assign wr_skey = sfr_req.wr && sfr_req.addr == SKEY_ADDR;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_s1_r <= 1'b0;
            irq_s2_r <= 1'b0;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
        end else begin
            irq_s1_r <= irq_any;
            irq_s2_r <= irq_s1_r;
            ext_s1_r <= ext_irq_any;
            ext_s2_r <= ext_s1_r;
        end
    end

    always_comb begin
        pctl_nxt   = pctl_r;
        skey_nxt   = skey_r;
        armed_nxt  = armed_r;
        st_nxt     = st_r;
        warm_nxt   = warm_r;
        pend_nxt   = pend_r;
        // cycles spent in warm-up, for the hold check
        seen_nxt   = (st_r == ST_WARM) ? seen_r + 1'b1 : '0;
        wake_nxt   = 1'b0;
        rd_nxt     = 8'h00;
        cpu_en_nxt = 1'b1;
        per_en_nxt = 1'b1;
        osc_nxt    = 1'b1;
        wdt_en_nxt = wdt_enabled;
        case (rd_addr)
            PCTL_ADDR: rd_nxt = pctl_r;
            SKEY_ADDR: rd_nxt = skey_r;
            default:   rd_nxt = 8'h00;
        endcase
        case (st_r)
            ST_RUN: begin
                if (wr_pctl) begin
                    pctl_nxt = sfr_req.data & PCTL_WR_MASK;
                    if (!armed_r) begin
                        // unkeyed mode request is dropped
                        pctl_nxt[BIT_IDLE]  = 1'b0;
                        pctl_nxt[BIT_PDOWN] = 1'b0;
                    end
                end
                if (wr_skey) begin
                    skey_nxt  = sfr_req.data;
                    armed_nxt = sfr_req.data == KEY_VALUE;
                end else if (sfr_req.instr_done || sfr_req.wr) begin
                    // next instruction consumes or breaks the key
                    armed_nxt = 1'b0;
                    skey_nxt  = SKEY_RESET;
                end
                if (armed_r && wr_pctl && sfr_req.data[BIT_PDOWN]) begin
                    st_nxt     = ST_PDOWN;
                    cpu_en_nxt = 1'b0;
                    per_en_nxt = 1'b0;
                    osc_nxt    = 1'b0;
                end else if (armed_r && wr_pctl && sfr_req.data[BIT_IDLE]) begin
                    st_nxt     = ST_IDLE;
                    cpu_en_nxt = 1'b0;
                end
            end
            ST_IDLE: begin
                cpu_en_nxt = 1'b0;
                if (irq_s2_r) begin
                    st_nxt              = ST_RUN;
                    pctl_nxt[BIT_IDLE]  = 1'b0;
                    skey_nxt            = SKEY_RESET;
                    armed_nxt           = 1'b0;
                    cpu_en_nxt          = 1'b1;
                    wake_nxt            = 1'b1;
                end
            end
            ST_PDOWN: begin
                cpu_en_nxt = 1'b0;
                per_en_nxt = 1'b0;
                osc_nxt    = 1'b0;
                if (ext_s2_r) begin
                    st_nxt   = ST_WARM;
                    osc_nxt  = 1'b1;
                    warm_nxt = '0;
                    pend_nxt = 1'b1;
                end
            end
            ST_WARM: begin
                cpu_en_nxt = 1'b0;
                per_en_nxt = 1'b0;
                warm_nxt   = warm_r + 1'b1;
                if (warm_r == WARM_W'(WARMUP_CYC - 1)) begin
                    st_nxt              = ST_RUN;
                    pctl_nxt[BIT_IDLE]  = 1'b0;
                    pctl_nxt[BIT_PDOWN] = 1'b0;
                    skey_nxt            = SKEY_RESET;
                    armed_nxt           = 1'b0;
                    cpu_en_nxt          = 1'b1;
                    per_en_nxt          = 1'b1;
                    // reset warm-up is no wake: core starts at reset vector
                    wake_nxt            = pend_r;
                    pend_nxt            = 1'b0;
                end
            end
            default: st_nxt = ST_RUN;
        endcase
    end

    // any reset restores clocks via warm-up
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pctl_r   <= PCTL_RESET;
            skey_r   <= SKEY_RESET;
            armed_r  <= 1'b0;
            st_r     <= ST_WARM;
            warm_r   <= '0;
            seen_r   <= '0;
            pend_r   <= 1'b0;
            wake_r   <= 1'b0;
            rd_r     <= 8'h00;
            cpu_en_r <= 1'b0;
            per_en_r <= 1'b0;
            osc_r    <= 1'b1;
            wdt_en_r <= 1'b0;
        end else begin
            pctl_r   <= pctl_nxt;
            skey_r   <= skey_nxt;
            armed_r  <= armed_nxt;
            st_r     <= st_nxt;
            warm_r   <= warm_nxt;
            seen_r   <= seen_nxt;
            pend_r   <= pend_nxt;
            wake_r   <= wake_nxt;
            rd_r     <= rd_nxt;
            cpu_en_r <= cpu_en_nxt;
            per_en_r <= per_en_nxt;
            osc_r    <= osc_nxt;
            wdt_en_r <= wdt_en_nxt;
        end
    end

    assign rd_data       = rd_r;
    assign cpu_clk_en    = cpu_en_r;
    assign periph_clk_en = per_en_r;
    assign osc_run       = osc_r;
    assign wdt_clk_en    = wdt_en_r;
    assign wake_irq      = wake_r;
    assign power_control = pctl_r;

    a_idle_entry: assert property (@(posedge sys_clk)
        disable iff (rst)
        st_r == ST_RUN && armed_r && wr_pctl && sfr_req.data[BIT_IDLE]
        && !sfr_req.data[BIT_PDOWN] |=> st_r == ST_IDLE ##0 !cpu_clk_en
        ##0 periph_clk_en) else $error("idle entry wrong");
    a_unkeyed_drop: assert property (@(posedge sys_clk)
        disable iff (rst)
        st_r == ST_RUN && !armed_r && wr_pctl |=> st_r == ST_RUN
        && pctl_r[1:0] == 2'b00) else $error("unkeyed entry");
    a_pdown_prio: assert property (@(posedge sys_clk)
        disable iff (rst)
        st_r == ST_RUN && armed_r && wr_pctl && sfr_req.data[BIT_PDOWN]
        |=> st_r == ST_PDOWN && !osc_run && !periph_clk_en)
        else $error("power-down entry wrong");
    a_key_consumed: assert property (@(posedge sys_clk)
        disable iff (rst)
        armed_r && !wr_skey && (sfr_req.instr_done || sfr_req.wr)
        && st_r == ST_RUN |=> !armed_r && skey_r == SKEY_RESET)
        else $error("key kept");
    a_idle_wake: assert property (@(posedge sys_clk)
        disable iff (rst)
        st_r == ST_IDLE && irq_s2_r |=> cpu_clk_en && wake_irq
        && !pctl_r[BIT_IDLE] && skey_r == SKEY_RESET)
        else $error("idle wake wrong");
    a_pdown_hold: assert property (@(posedge sys_clk)
        disable iff (rst)
        st_r == ST_PDOWN && !ext_s2_r |=> !cpu_clk_en && !periph_clk_en
        && wdt_clk_en == $past(wdt_enabled)) else $error("power-down leak");
    a_warm_hold: assert property (@(posedge sys_clk)
        disable iff (rst)
        $rose(cpu_clk_en) && $past(st_r) == ST_WARM
        |-> seen_r == WARM_W'(WARMUP_CYC))
        else $error("cpu clock before warm-up");
    a_pdown_exit: assert property (@(posedge sys_clk)
        disable iff (rst)
        $past(st_r) == ST_WARM && st_r == ST_RUN |-> pctl_r[1:0] == 2'b00
        && skey_r == SKEY_RESET && cpu_clk_en && periph_clk_en)
        else $error("power-down exit bits");
endmodule

// *** rtl/suspend_pkg.sv ***
/*
 power management constants: power_control and suspend key register
 layout, reset values, state encodings and warm-up count.
 assumes an 8-bit special-function-register bus from the cpu core.
*/
package suspend_pkg;
    localparam logic [7:0] PCTL_ADDR      = 8'h87;
    localparam logic [7:0] SKEY_ADDR      = 8'h8e;
    localparam logic [7:0] KEY_VALUE      = 8'h55;
    localparam logic [7:0] PCTL_RESET     = 8'h00;
    localparam logic [7:0] SKEY_RESET     = 8'h00;
    localparam logic [7:0] PCTL_WR_MASK   = 8'hcf;
    localparam int         BIT_IDLE       = 0;
    localparam int         BIT_PDOWN      = 1;
    localparam int         BIT_GF_LO      = 2;
    localparam int         BIT_GF_HI      = 3;
    localparam int         BIT_SER_SEL    = 6;
    localparam int         BIT_BAUD2      = 7;
    localparam int         WARMUP_CYC_DEF = 128;
    localparam int         WARM_W         = 16;

    typedef enum logic [3:0] {
        ST_RUN   = 4'b0001,
        ST_IDLE  = 4'b0010,
        ST_PDOWN = 4'b0100,
        ST_WARM  = 4'b1000
    } pm_state_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic       instr_done;
    } sfr_req_t;
endpackage

// *** test/cpu_core_model.sv ***
/* cpu core model: issues sfr writes and nop completions.
 assumes the bench calls its tasks at a falling edge of sys_clk. */
`timescale 1ns/1ps
module cpu_core_model
    import suspend_pkg::*;
(
    // clock and status
    input  wire logic sys_clk,
    input  wire logic cpu_clk_en,
    // sfr requests
    output sfr_req_t  sfr_req
);
    initial sfr_req = '0;
    // one write; hold keeps the bus for a back-to-back write
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic hold);
        sfr_req = '{1'b1, a, d, 1'b0};
        @(negedge sys_clk);
        if (!hold)
            sfr_req = '{1'b0, ~a, ~d, 1'b0};
    endtask
    // nops only run while the cpu clock runs
    task automatic nops(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            while (cpu_clk_en !== 1'b1)
                @(negedge sys_clk);
            sfr_req.instr_done = 1'b1;
            @(negedge sys_clk);
            sfr_req.instr_done = 1'b0;
        end
    endtask
endmodule

// *** test/tb_suspend_mode_controller.sv ***
/* self-checking bench for the suspend mode controller.
 assumes the cpu core model above; 100 MHz clock. */
`timescale 1ns/1ps
module tb_suspend_mode_controller;
    import suspend_pkg::*;
    localparam int WU = 4;
    logic       sys_clk = 0, rst = 1, irq_any = 0, ext_irq_any = 0;
    logic       wdt_enabled = 0;
    logic [7:0] rd_addr = '0, v;
    logic [7:0] rd_data, power_control;
    logic       cpu_clk_en, periph_clk_en, osc_run, wdt_clk_en, wake_irq;
    sfr_req_t   sfr_req;
    int         error_cnt = 0, n_tests = 0, cyc = 0;
    always #5 sys_clk = ~sys_clk;
    cpu_core_model cpu_u (.sys_clk(sys_clk), .cpu_clk_en(cpu_clk_en),
                          .sfr_req(sfr_req));
    suspend_mode_controller #(.WARMUP_CYC(WU)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .sfr_req(sfr_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .irq_any(irq_any),
        .ext_irq_any(ext_irq_any), .wdt_enabled(wdt_enabled),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .osc_run(osc_run), .wdt_clk_en(wdt_clk_en), .wake_irq(wake_irq),
        .power_control(power_control));
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk);
        rd_addr = a;
        @(negedge sys_clk);
    endtask
    task automatic wait_cpu(input int n);
        for (int i = 0; i < n && cpu_clk_en !== 1'b1; i++)
            @(negedge sys_clk);
        chk("cpu_clk_en", {7'h0, cpu_clk_en}, 8'h01);
    endtask
    function automatic logic [7:0] exp_pctl(input logic [7:0] d);
        return d & PCTL_WR_MASK & 8'hfc;
    endfunction
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            tally_and_finish;
        end
    end
    initial begin
        void'($urandom(3));
        repeat (3) @(negedge sys_clk);
        rst = 0;
        chk("pctl_reset", power_control, PCTL_RESET);
        chk("cpu_warm", {7'h0, cpu_clk_en}, 8'h00);
        wait_cpu(WU + 4);
        chk("rst_wake", {7'h0, wake_irq}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'hff : 8'($urandom);
            cpu_u.wr(PCTL_ADDR, v, 1'b0);
            rd(PCTL_ADDR);
            chk("pctl_rw", rd_data, exp_pctl(v));
            chk("still_run", {7'h0, cpu_clk_en}, 8'h01);
        end
        cpu_u.wr(PCTL_ADDR, 8'h00, 1'b0);
        rd(8'h42);
        chk("unmapped", rd_data, 8'h00);
        cpu_u.wr(SKEY_ADDR, KEY_VALUE, 1'b0);
        cpu_u.nops(1);
        cpu_u.wr(PCTL_ADDR, 8'h01, 1'b0);
        rd(PCTL_ADDR);
        chk("broken", {6'h0, rd_data[0], cpu_clk_en}, 8'h01);
        cpu_u.wr(SKEY_ADDR, KEY_VALUE, 1'b1);
        cpu_u.wr(8'h42, 8'h00, 1'b1);
        cpu_u.wr(PCTL_ADDR, 8'h02, 1'b0);
        rd(PCTL_ADDR);
        chk("brk_wr", {6'h0, rd_data[1], cpu_clk_en}, 8'h01);
        for (int m = 1; m < 4; m++) begin
            wdt_enabled = m[0];
            cpu_u.wr(SKEY_ADDR, KEY_VALUE, 1'b1);
            cpu_u.wr(PCTL_ADDR, m[7:0], 1'b0);
            repeat (2) @(negedge sys_clk);
            chk("clk_off", {6'h0, cpu_clk_en, periph_clk_en},
                (m == 1) ? 8'h01 : 8'h00);
            chk("pctl_set", power_control, m[7:0]);
            if (m > 1)
                chk("pdown_osc", {6'h0, osc_run, wdt_clk_en},
                    {7'h0, m[0]});
            irq_any = 1;
            if (m > 1) begin
                repeat (6) @(negedge sys_clk);
                chk("pdown_hold", {7'h0, cpu_clk_en}, 8'h00);
                ext_irq_any = 1;
                repeat (3) @(negedge sys_clk);
                chk("osc_up", {6'h0, osc_run, cpu_clk_en},
                    8'h02);
            end
            wait_cpu((m == 1) ? 6 : WU + 12);
            chk("wake", {7'h0, wake_irq}, 8'h01);
            irq_any = 0;
            ext_irq_any = 0;
            chk("pctl_clr", power_control, 8'h00);
            rd(SKEY_ADDR);
            chk("key_clr", rd_data, SKEY_RESET);
            cpu_u.nops(3);
        end
        cpu_u.wr(SKEY_ADDR, KEY_VALUE, 1'b1);
        cpu_u.wr(PCTL_ADDR, 8'h02, 1'b0);
        repeat (2) @(negedge sys_clk);
        rst = 1;
        @(negedge sys_clk);
        rst = 0;
        chk("rst_pdown", {power_control[1:0], 5'h0, cpu_clk_en},
            8'h00);
        wait_cpu(WU + 4);
        chk("rst_wake2", {7'h0, wake_irq}, 8'h00);
        rd(SKEY_ADDR);
        chk("rst_key", rd_data, SKEY_RESET);
        tally_and_finish;
    end
endmodule
